// ===== src/shc_host_ctrl.v
/*
 * SMBus host cycle control with AHB-Lite register slave, bit engine and block FIFO.
 * Assumes one AHB-Lite master, word accesses, and external resolution of open-drain pins.
 */
// Behaviour
// - Enabled events go to management or configuration interrupt per route select bit.
// - Control bit 10 enables alert-pin status interrupt, only with alert function selected.
// - Control bit 9 enables slave address match status interrupt.
// - Control bit 8 enables snoop match status interrupt.
// - Writing one to bit 5 forces a stop soon, waiting out slave-driven zeros in read phases.
// - After the abort stop completes, the abort status flag is set.
// - Control bit 4 enables one interrupt for five host status flags.
// - Writing one to bit 3 starts the programmed bus cycle.
// - Start writes are ignored while host busy.
// - Cycle type sits in bits 2:0; writes ignored while busy.
// - Byte cycles use data low byte; ten-bit pattern receives second byte high.
// - Type 2 is byte read or write with command and data low byte.
// - Type 3 is word read or write with command and full data word.
// - Type 4 process call sends data word, then overwrites it with read word.
// - Type 5 block transfer uses command, count in data 5:0 on write or first read byte on read, FIFO bytes.
// - Address register bit 0 selects read when one, write when zero.
// - Host busy status reads one while a cycle runs.
// - Cycle done status is set when a cycle finishes successfully.
`timescale 1ns/1ps
`include "shc_defines.vh"

module shc_host_ctrl #(
  parameter TO_CYC = `SHC_TO_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire smb_clk_i,
  output reg smb_clk_o,
  output reg smb_clk_oe_n,
  input wire smb_dat_i,
  output reg smb_dat_o,
  output reg smb_dat_oe_n,
  input wire alert_pin_n,
  input wire slave_match_evt,
  input wire snoop_match_evt,
  output reg system_management_interrupt,
  output reg configuration_interrupt
);
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_BYTE = 3'h2;
  localparam ST_RSTRT = 3'h3;
  localparam ST_STOP = 3'h4;
  localparam ST_NEXT = 3'h5;
  localparam P_ADDR = 3'h0;
  localparam P_CMD = 3'h1;
  localparam P_WR = 3'h2;
  localparam P_ADDR2 = 3'h3;
  localparam P_RD = 3'h4;

  reg [15:0] gctl_q;
  reg [2:0] cycle_type_q;
  reg [15:0] host_status_reg_q;
  reg [15:0] host_address_reg_q;
  reg [15:0] host_data_reg_q;
  reg [7:0] host_command_reg_q;
  reg [1:0] pm_control_reg_q;
  reg [7:0] fifo_q [0:31];
  reg [4:0] sw_ptr_q;
  reg wr_pend_q, rd_pend_q;
  reg [7:0] a_q;
  reg scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q, alr_s1_q, alr_s2_q;
  reg [6:0] div_q;
  reg [19:0] to_cnt_q;
  reg host_busy_q, abort_q, err_q;
  reg [2:0] st_q, ph_q;
  reg [1:0] q_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [5:0] n_q, idx_q;
  reg ev_done_q, ev_to_q, ev_prerr_q, ev_col_q, ev_abrt_q;
  reg [15:0] sts_set;
  reg [15:0] rmux;

  wire ap = hsel & htrans[1] & hready;
  wire gwr = wr_pend_q & (a_q == `SHC_A_GCTL);
  wire tick = (div_q == `SHC_QTR_CYC - 1);
  wire rdir = host_address_reg_q[0];
  wire ten = (host_address_reg_q[7:3] == `SHC_TEN_PAT);
  wire rx = (ph_q == P_RD);
  wire blk_first = (cycle_type_q == `SHC_CT_BLOCK) && (idx_q == 6'h00);
  wire last = blk_first ? (sh_q[5:0] == 6'h00) : (n_q == 6'h01);
  wire at_ack = (bit_q == 4'h8);
  wire dbit = rx ? (at_ack ? last : 1'b1) : (at_ack ? 1'b1 : sh_q[7]);
  wire [4:0] fidx = idx_q[4:0] - 5'h01;
  wire [7:0] fifo_out = fifo_q[fidx];
  wire [7:0] addr1 = (cycle_type_q == `SHC_CT_QUICK || cycle_type_q == `SHC_CT_BYTE) ?
                     host_address_reg_q[7:0] : {host_address_reg_q[7:1], 1'b0};

  // Byte sent at a given index of the data phase.
  function [7:0] wsel;
    input [2:0] t;
    input [5:0] i;
    input [15:0] d;
    input [7:0] f;
    begin
      if (t == `SHC_CT_BLOCK)
        wsel = (i == 6'h00) ? {2'b00, d[5:0]} : f;
      else
        wsel = (i == 6'h00) ? d[7:0] : d[15:8];
    end
  endfunction

  // Number of data bytes for a cycle type.
  function [5:0] nbytes;
    input [2:0] t;
    input [5:0] cnt;
    input two;
    begin
      case (t)
        `SHC_CT_BYTE: nbytes = two ? 6'h02 : 6'h01;
        `SHC_CT_WORD, `SHC_CT_PROC: nbytes = 6'h02;
        `SHC_CT_BLOCK: nbytes = cnt + 6'h01;
        default: nbytes = 6'h01;
      endcase
    end
  endfunction

  always @* begin
    case (a_q)
      `SHC_A_GCTL: rmux = (gctl_q & `SHC_GC_KEEP) | (gctl_q & `SHC_GC_HEN_MASK) |
                          {13'h0000, cycle_type_q};
      `SHC_A_STS: rmux = host_status_reg_q | ({15'h0000, host_busy_q} << `SHC_ST_BUSY);
      `SHC_A_ADDR: rmux = host_address_reg_q;
      `SHC_A_DATA: rmux = host_data_reg_q;
      `SHC_A_CMD: rmux = {8'h00, host_command_reg_q};
      `SHC_A_FIFO: rmux = host_busy_q ? 16'h0000 : {8'h00, fifo_q[sw_ptr_q]};
      `SHC_A_PMC: rmux = {14'h0000, pm_control_reg_q};
      default: rmux = 16'h0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      alr_s1_q <= 1'b1;
      alr_s2_q <= 1'b1;
    end else begin
      scl_s1_q <= smb_clk_i;
      scl_s2_q <= scl_s1_q;
      sda_s1_q <= smb_dat_i;
      sda_s2_q <= sda_s1_q;
      alr_s1_q <= alert_pin_n;
      alr_s2_q <= alr_s1_q;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      a_q <= 8'h00;
    end else begin
      wr_pend_q <= ap & hwrite;
      rd_pend_q <= ap & ~hwrite;
      if (ap)
        a_q <= haddr[7:0];
      if (ap & ~hwrite)
        hreadyout <= 1'b0;
      else if (rd_pend_q) begin
        hreadyout <= 1'b1;
        hrdata <= {16'h0000, rmux};
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gctl_q <= `SHC_GC_RST;
      cycle_type_q <= 3'h0;
      host_address_reg_q <= 16'h0000;
      host_data_reg_q <= 16'h0000;
      host_command_reg_q <= 8'h00;
      pm_control_reg_q <= 2'h0;
      sw_ptr_q <= 5'h00;
      smb_clk_o <= 1'b0;
      smb_dat_o <= 1'b0;
      smb_clk_oe_n <= 1'b1;
      smb_dat_oe_n <= 1'b1;
      div_q <= 7'h00;
      to_cnt_q <= 20'h00000;
      host_busy_q <= 1'b0;
      abort_q <= 1'b0;
      err_q <= 1'b0;
      st_q <= ST_IDLE;
      ph_q <= P_ADDR;
      q_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      n_q <= 6'h00;
      idx_q <= 6'h00;
      ev_done_q <= 1'b0;
      ev_to_q <= 1'b0;
      ev_prerr_q <= 1'b0;
      ev_col_q <= 1'b0;
      ev_abrt_q <= 1'b0;
    end else begin
      ev_done_q <= 1'b0;
      ev_to_q <= 1'b0;
      ev_prerr_q <= 1'b0;
      ev_col_q <= 1'b0;
      ev_abrt_q <= 1'b0;
      div_q <= tick ? 7'h00 : div_q + 7'h01;
      if (wr_pend_q) begin
        case (a_q)
          `SHC_A_GCTL: gctl_q <= hwdata[15:0] & (`SHC_GC_KEEP | `SHC_GC_HEN_MASK);
          `SHC_A_ADDR: host_address_reg_q <= hwdata[15:0];
          `SHC_A_DATA: host_data_reg_q <= hwdata[15:0];
          `SHC_A_CMD: host_command_reg_q <= hwdata[7:0];
          `SHC_A_PMC: pm_control_reg_q <= hwdata[1:0];
          `SHC_A_FIFO: begin
            if (!host_busy_q) begin
              fifo_q[sw_ptr_q] <= hwdata[7:0];
              sw_ptr_q <= sw_ptr_q + 5'h01;
            end
          end
          default: ;
        endcase
      end
      if (rd_pend_q && a_q == `SHC_A_FIFO && !host_busy_q)
        sw_ptr_q <= sw_ptr_q + 5'h01;
      if (gwr && !host_busy_q)
        cycle_type_q <= hwdata[2:0];
      if (gwr && hwdata[`SHC_GC_ABORT] && host_busy_q)
        abort_q <= 1'b1;
      if (gwr && hwdata[`SHC_GC_START] && !host_busy_q) begin
        host_busy_q <= 1'b1;
        st_q <= ST_START;
        ph_q <= P_ADDR;
        q_q <= 2'h0;
        err_q <= 1'b0;
      end
      if (host_busy_q) begin
        to_cnt_q <= scl_s2_q ? 20'h00000 : to_cnt_q + 20'h00001;
        if (to_cnt_q == TO_CYC) begin
          ev_to_q <= 1'b1;
          host_busy_q <= 1'b0;
          abort_q <= 1'b0;
          st_q <= ST_IDLE;
          smb_clk_oe_n <= 1'b1;
          smb_dat_oe_n <= 1'b1;
          sw_ptr_q <= 5'h00;
        end else if (st_q == ST_NEXT) begin
          st_q <= ST_BYTE;
          q_q <= 2'h0;
          bit_q <= 4'h0;
          idx_q <= 6'h00;
          case (ph_q)
            P_ADDR: begin
              if (cycle_type_q == `SHC_CT_QUICK)
                st_q <= ST_STOP;
              else if (cycle_type_q == `SHC_CT_BYTE) begin
                ph_q <= rdir ? P_RD : P_WR;
                n_q <= nbytes(cycle_type_q, 6'h00, rdir & ten);
                sh_q <= host_data_reg_q[7:0];
              end else begin
                ph_q <= P_CMD;
                sh_q <= host_command_reg_q;
              end
            end
            P_CMD: begin
              if (rdir && cycle_type_q != `SHC_CT_PROC) begin
                st_q <= ST_RSTRT;
                q_q <= 2'h0;
              end else begin
                ph_q <= P_WR;
                n_q <= nbytes(cycle_type_q, host_data_reg_q[5:0], 1'b0);
                sh_q <= wsel(cycle_type_q, 6'h00, host_data_reg_q, fifo_out);
              end
            end
            P_WR: begin
              if (n_q == 6'h01)
                st_q <= (cycle_type_q == `SHC_CT_PROC) ? ST_RSTRT : ST_STOP;
              else begin
                n_q <= n_q - 6'h01;
                idx_q <= idx_q + 6'h01;
                sh_q <= wsel(cycle_type_q, idx_q + 6'h01, host_data_reg_q, fifo_q[idx_q[4:0]]);
              end
            end
            P_ADDR2: begin
              ph_q <= P_RD;
              n_q <= (cycle_type_q == `SHC_CT_BLOCK) ? 6'h01 : nbytes(cycle_type_q, 6'h00, 1'b0);
            end
            default: begin
              idx_q <= idx_q + 6'h01;
              if (cycle_type_q == `SHC_CT_BLOCK) begin
                if (idx_q != 6'h00)
                  fifo_q[fidx] <= sh_q;
              end else if (idx_q == 6'h00)
                host_data_reg_q[7:0] <= sh_q;
              else
                host_data_reg_q[15:8] <= sh_q;
              if (blk_first && sh_q[5:0] != 6'h00)
                n_q <= sh_q[5:0];
              else if (n_q == 6'h01)
                st_q <= ST_STOP;
              else
                n_q <= n_q - 6'h01;
            end
          endcase
        end else if (tick) begin
          case (st_q)
            ST_START: begin
              case (q_q)
                2'h0: begin
                  smb_dat_oe_n <= 1'b1;
                  smb_clk_oe_n <= 1'b1;
                  q_q <= 2'h1;
                end
                2'h1: begin
                  if (scl_s2_q && sda_s2_q) begin
                    smb_dat_oe_n <= 1'b0;
                    q_q <= 2'h2;
                  end
                end
                2'h2: q_q <= 2'h3;
                default: begin
                  smb_clk_oe_n <= 1'b0;
                  sh_q <= (ph_q == P_ADDR2) ? {host_address_reg_q[7:1], 1'b1} : addr1;
                  st_q <= ST_BYTE;
                  q_q <= 2'h0;
                  bit_q <= 4'h0;
                end
              endcase
            end
            ST_BYTE: begin
              case (q_q)
                2'h0: begin
                  if (abort_q && !(rx && !sda_s2_q)) begin
                    st_q <= ST_STOP;
                  end else begin
                    smb_dat_oe_n <= dbit;
                    q_q <= 2'h1;
                  end
                end
                2'h1: begin
                  smb_clk_oe_n <= 1'b1;
                  q_q <= 2'h2;
                end
                2'h2: begin
                  if (scl_s2_q) begin
                    q_q <= 2'h3;
                    if (!at_ack) begin
                      sh_q <= {sh_q[6:0], sda_s2_q};
                      if (!rx && sh_q[7] && !sda_s2_q) begin
                        ev_col_q <= 1'b1;
                        host_busy_q <= 1'b0;
                        abort_q <= 1'b0;
                        st_q <= ST_IDLE;
                        smb_dat_oe_n <= 1'b1;
                        sw_ptr_q <= 5'h00;
                      end
                    end else if (!rx && sda_s2_q) begin
                      ev_prerr_q <= 1'b1;
                      err_q <= 1'b1;
                      sw_ptr_q <= 5'h00;
                    end
                  end
                end
                default: begin
                  smb_clk_oe_n <= 1'b0;
                  q_q <= 2'h0;
                  bit_q <= bit_q + 4'h1;
                  if (at_ack)
                    st_q <= err_q ? ST_STOP : ST_NEXT;
                end
              endcase
            end
            ST_RSTRT: begin
              if (q_q == 2'h0) begin
                smb_dat_oe_n <= 1'b1;
                q_q <= 2'h1;
              end else begin
                smb_clk_oe_n <= 1'b1;
                ph_q <= P_ADDR2;
                st_q <= ST_START;
                q_q <= 2'h1;
              end
            end
            ST_STOP: begin
              case (q_q)
                2'h0: begin
                  smb_dat_oe_n <= 1'b0;
                  q_q <= 2'h1;
                end
                2'h1: begin
                  smb_clk_oe_n <= 1'b1;
                  q_q <= 2'h2;
                end
                2'h2: begin
                  if (scl_s2_q)
                    q_q <= 2'h3;
                end
                default: begin
                  smb_dat_oe_n <= 1'b1;
                  host_busy_q <= 1'b0;
                  st_q <= ST_IDLE;
                  q_q <= 2'h0;
                  sw_ptr_q <= 5'h00;
                  abort_q <= 1'b0;
                  ev_abrt_q <= abort_q;
                  ev_done_q <= ~abort_q & ~err_q;
                end
              endcase
            end
            default: st_q <= ST_IDLE;
          endcase
        end
      end else
        to_cnt_q <= 20'h00000;
    end
  end

  always @* begin
    sts_set = 16'h0000;
    sts_set[`SHC_ST_ALERT] = pm_control_reg_q[`SHC_PM_ALFN] & ~alr_s2_q;
    sts_set[`SHC_ST_SLV] = slave_match_evt;
    sts_set[`SHC_ST_SNP] = snoop_match_evt;
    sts_set[`SHC_ST_TO] = ev_to_q;
    sts_set[`SHC_ST_DONE] = ev_done_q;
    sts_set[`SHC_ST_PRERR] = ev_prerr_q;
    sts_set[`SHC_ST_COL] = ev_col_q;
    sts_set[`SHC_ST_ABRT] = ev_abrt_q;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_status_reg_q <= 16'h0000;
      system_management_interrupt <= 1'b0;
      configuration_interrupt <= 1'b0;
    end else begin
      if (wr_pend_q && a_q == `SHC_A_STS)
        host_status_reg_q <= (host_status_reg_q & ~(hwdata[15:0] & `SHC_STS_W1C)) | sts_set;
      else
        host_status_reg_q <= host_status_reg_q | sts_set;
      system_management_interrupt <= ~pm_control_reg_q[`SHC_PM_ROUTE] & (
        (gctl_q[`SHC_GC_ALERT_EN] & host_status_reg_q[`SHC_ST_ALERT]) |
        (gctl_q[`SHC_GC_SLV_EN] & host_status_reg_q[`SHC_ST_SLV]) |
        (gctl_q[`SHC_GC_SNP_EN] & host_status_reg_q[`SHC_ST_SNP]) |
        (gctl_q[`SHC_GC_HOST_EN] & |(host_status_reg_q & `SHC_STS_HOST)));
      configuration_interrupt <= pm_control_reg_q[`SHC_PM_ROUTE] & (
        (gctl_q[`SHC_GC_ALERT_EN] & host_status_reg_q[`SHC_ST_ALERT]) |
        (gctl_q[`SHC_GC_SLV_EN] & host_status_reg_q[`SHC_ST_SLV]) |
        (gctl_q[`SHC_GC_SNP_EN] & host_status_reg_q[`SHC_ST_SNP]) |
        (gctl_q[`SHC_GC_HOST_EN] & |(host_status_reg_q & `SHC_STS_HOST)));
    end
  end
endmodule // shc_host_ctrl

// ===== src/shc_defines.vh
/*
 * Constants for the SMBus host cycle control block: register offsets, field positions,
 * reset values, cycle type codes and timing figures.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef SHC_DEFINES_VH
`define SHC_DEFINES_VH

`define SHC_A_GCTL 8'h00
`define SHC_A_STS 8'h04
`define SHC_A_ADDR 8'h08
`define SHC_A_DATA 8'h0C
`define SHC_A_CMD 8'h10
`define SHC_A_FIFO 8'h14
`define SHC_A_PMC 8'h18

`define SHC_GC_ALERT_EN 10
`define SHC_GC_SLV_EN 9
`define SHC_GC_SNP_EN 8
`define SHC_GC_ABORT 5
`define SHC_GC_HOST_EN 4
`define SHC_GC_START 3
`define SHC_GC_KEEP 16'h0700
`define SHC_GC_HEN_MASK 16'h0010
`define SHC_GC_RST 16'h0000

`define SHC_ST_ALERT 10
`define SHC_ST_SLV 9
`define SHC_ST_SNP 8
`define SHC_ST_TO 5
`define SHC_ST_DONE 4
`define SHC_ST_BUSY 3
`define SHC_ST_PRERR 2
`define SHC_ST_COL 1
`define SHC_ST_ABRT 0
`define SHC_STS_W1C 16'h0737
`define SHC_STS_HOST 16'h0037

`define SHC_PM_ROUTE 0
`define SHC_PM_ALFN 1

`define SHC_CT_QUICK 3'h0
`define SHC_CT_BYTE 3'h1
`define SHC_CT_BDATA 3'h2
`define SHC_CT_WORD 3'h3
`define SHC_CT_PROC 3'h4
`define SHC_CT_BLOCK 3'h5
`define SHC_TEN_PAT 5'h1E

`define SHC_CLK_MHZ 40
`define SHC_QTR_NS 2500
`define SHC_QTR_CYC ((`SHC_QTR_NS * `SHC_CLK_MHZ) / 1000)
`define SHC_TO_US 25000
`define SHC_TO_CYC (`SHC_TO_US * `SHC_CLK_MHZ)

`endif

// ===== testbench/shc_chk.sv
/* Assertion checker for the SMBus host cycle control block.
   Assumes it is bound to shc_host_ctrl and sees only that module's ports. */
`timescale 1ns/1ps
module shc_chk #(
  parameter TO_CYC = 2000
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire smb_clk_o,
  input wire smb_clk_oe_n,
  input wire smb_dat_o,
  input wire smb_dat_oe_n,
  input wire slave_match_evt,
  input wire snoop_match_evt,
  input wire system_management_interrupt,
  input wire configuration_interrupt
);
  reg [15:0] en_q;
  reg rt_q;
  reg wph_q;
  reg [7:0] wa_q;
  wire irq = system_management_interrupt | configuration_interrupt;
  wire gc_wr = wph_q && wa_q == 8'h00 && hready;
  // Shadow of the enable bits and the routing bit, taken from bus writes.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph_q <= 1'b0;
      wa_q <= 8'h00;
      en_q <= 16'h0000;
      rt_q <= 1'b0;
    end else if (hready) begin
      if (gc_wr) en_q <= hwdata[15:0];
      if (wph_q && wa_q == 8'h18) rt_q <= hwdata[0];
      wph_q <= hsel && htrans[1] && hwrite;
      wa_q <= haddr[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_take;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  hresp_okay_a: assert property (!hresp) else $error("response not OKAY");
  od_low_a: assert property (!smb_clk_o && !smb_dat_o) else $error("pin data not low");
  rd_wait_a: assert property (rd_take |=> one_wait) else $error("read wait not one cycle");
  wr_nowait_a: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write was stalled");
  irq_excl_a: assert property (!(system_management_interrupt && configuration_interrupt))
    else $error("both interrupts high");
  irq_route_a: assert property (irq && rt_q == $past(rt_q, 3) |-> configuration_interrupt == rt_q)
    else $error("interrupt on wrong output");
  slv_irq_a: assert property (slave_match_evt && en_q[9] |-> ##[1:4] irq)
    else $error("slave match gave no interrupt");
  snp_irq_a: assert property (snoop_match_evt && en_q[8] |-> ##[1:4] irq)
    else $error("snoop match gave no interrupt");
  irq_quiet_a: assert property ((en_q & 16'h0710) == 16'h0000 &&
    ($past(en_q, 3) & 16'h0710) == 16'h0000 |-> !irq) else $error("interrupt while disabled");
  start_drive_a: assert property (gc_wr && hwdata[3] |-> ##[1:1000] !smb_dat_oe_n)
    else $error("start gave no bus activity");
  abort_stop_a: assert property (gc_wr && hwdata[5] && !smb_clk_oe_n |->
    ##[1:1000] ($rose(smb_dat_oe_n) && smb_clk_oe_n)) else $error("abort gave no stop");
endmodule // shc_chk

bind shc_host_ctrl shc_chk #(.TO_CYC(TO_CYC)) u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .smb_clk_o, .smb_clk_oe_n, .smb_dat_o,
  .smb_dat_oe_n, .slave_match_evt, .snoop_match_evt, .system_management_interrupt,
  .configuration_interrupt);

// ===== testbench/shc_slave_model.sv
/* Behavioural SMBus slave: records the first four bytes after a start and acknowledges the address and written bytes.
   Assumes open-drain lines resolved by the bench with pull-ups. */
`timescale 1ns/1ps
module shc_slave_model (
  input wire scl,
  input wire sda,
  input wire nack_en,
  output reg sda_low
);
  reg [7:0] sh;
  reg [7:0] seen [0:3];
  reg rd;
  integer nb;
  integer ny;
  initial begin
    sda_low = 1'b0;
    sh = 8'h00;
    rd = 1'b0;
    nb = 0;
    ny = 0;
  end
  // A falling data line with the clock high is a start.
  always @(negedge sda) if (scl === 1'b1) begin
    nb = -1;
    ny = 0;
  end
  always @(posedge scl) if (nb < 8) sh = {sh[6:0], sda};
  // Read bytes are left to the pull-up, so the host reads ones.
  always @(negedge scl) begin
    nb = nb + 1;
    if (nb == 8) begin
      if (ny < 4) seen[ny] = sh;
      if (ny == 0) rd = sh[0];
      sda_low <= !nack_en && (ny == 0 || !rd);
    end else if (nb == 9) begin
      sda_low <= 1'b0;
      nb = 0;
      ny = ny + 1;
    end
  end
endmodule // shc_slave_model

// ===== testbench/tb_top.sv
/* Self-checking bench for the SMBus host cycle control block.
   Assumes one AHB-Lite master here and the slave model on the pins. */
`timescale 1ns/1ps
module tb_top;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'b00;
  reg hwrite = 1'b0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] hwdata = 32'h0;
  reg alert_pin_n = 1'b1;
  reg slave_match_evt = 1'b0;
  reg snoop_match_evt = 1'b0;
  reg nack_en = 1'b0;
  reg dph = 1'b0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, smb_clk_o, smb_clk_oe_n, smb_dat_o, smb_dat_oe_n, sda_low;
  wire system_management_interrupt, configuration_interrupt;
  wire hready = hreadyout;
  wire smb_clk_i = smb_clk_oe_n;
  wire smb_dat_i = smb_dat_oe_n & ~sda_low;
  wire [15:0] irqs = {14'h0, configuration_interrupt, system_management_interrupt};
  integer errors = 0;
  integer n_checks = 0;
  integer i;
  integer k;
  reg [15:0] rd;
  reg [15:0] wd;
  reg [31:0] lfsr = 32'h57EC;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  always #12.5 hclk = ~hclk;
  shc_host_ctrl #(.TO_CYC(2000)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .smb_clk_i, .smb_clk_o, .smb_clk_oe_n,
    .smb_dat_i, .smb_dat_o, .smb_dat_oe_n, .alert_pin_n, .slave_match_evt, .snoop_match_evt,
    .system_management_interrupt, .configuration_interrupt);
  shc_slave_model slv (.scl(smb_clk_i), .sda(smb_dat_i), .nack_en, .sda_low);
  function [31:0] lfsr_n(input [31:0] v);
    lfsr_n = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task close_out;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] want);
    n_checks = n_checks + 1;
    if (got !== want) begin
      errors = errors + 1;
      $display("unexpected %0t: got %h want %h", $time, got, want);
    end
  endtask
  task hwait;
    integer n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 9) begin
      @(posedge hclk);
      n = n + 1;
    end
    if (n >= 9) begin
      errors = errors + 1;
      $display("unexpected %0t: bus wait timed out", $time);
      close_out;
    end
  endtask
  task ahb(input w, input [7:0] a, input [15:0] d, input [15:0] e, input [15:0] m);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    hwait;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0, d};
    hwait;
    rd = hrdata[15:0];
  endtask
  task wr(input [7:0] a, input [15:0] d);
    ahb(1'b1, a, d, 16'h0, 16'h0);
  endtask
  task rdc(input [7:0] a, input [15:0] e, input [15:0] m);
    ahb(1'b0, a, 16'h0, e, m);
  endtask
  task go(input [2:0] t);
    wr(8'h00, {13'h0002, t});
    wr(8'h00, {13'h0003, t});
  endtask
  task idle;
    rd = 16'hFFFF;
    for (i = 0; i < 20000 && rd[3] !== 1'b0; i = i + 1) rdc(8'h04, 16'h0, 16'h0);
    if (i >= 20000) begin
      errors = errors + 1;
      $display("unexpected %0t: host stayed busy", $time);
      close_out;
    end
  endtask
  task pulse(input s);
    @(posedge hclk);
    slave_match_evt <= !s;
    snoop_match_evt <= s;
    @(posedge hclk);
    slave_match_evt <= 1'b0;
    snoop_match_evt <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  // Read results are compared with the oldest note when the data phase ends.
  always @(posedge hclk) begin
    if (dph && hreadyout) begin
      dph <= 1'b0;
      n_checks = n_checks + 1;
      if (((hrdata[15:0] ^ exp_q[0]) & msk_q[0]) !== 16'h0000) begin
        errors = errors + 1;
        $display("unexpected %0t: read %h want %h", $time, hrdata[15:0], exp_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end else if (hsel && htrans[1] && hready && !hwrite) begin
      dph <= 1'b1;
    end
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(8'h00, 16'h0000, 16'hFFFF);
    rdc(8'h04, 16'h0000, 16'hFFFF);
    rdc(8'h1C, 16'h0000, 16'hFFFF);
    wr(8'h00, 16'hFFD7);
    rdc(8'h00, 16'h0717, 16'hFFFF);
    for (k = 0; k < 2; k = k + 1) begin
      wr(8'h00, 16'h0000);
      wr(8'h18, k[15:0]);
      pulse(k[0]);
      chk(irqs, 16'h0000);
      wr(8'h00, k ? 16'h0100 : 16'h0200);
      repeat (4) @(posedge hclk);
      chk(irqs, k ? 16'h0002 : 16'h0001);
      wr(8'h04, 16'h0737);
      pulse(k[0]);
      chk(irqs, k ? 16'h0002 : 16'h0001);
      wr(8'h04, 16'h0737);
    end
    wr(8'h00, 16'h0400);
    wr(8'h18, 16'h0000);
    alert_pin_n <= 1'b0;
    repeat (6) @(posedge hclk);
    chk(irqs, 16'h0000);
    wr(8'h18, 16'h0002);
    repeat (6) @(posedge hclk);
    chk(irqs, 16'h0001);
    alert_pin_n <= 1'b1;
    wr(8'h18, 16'h0000);
    wr(8'h04, 16'h0737);
    for (k = 0; k < 2; k = k + 1) begin
      wr(8'h08, 16'h00A0 | k[15:0]);
      go(3'h0);
      rdc(8'h04, 16'h0008, 16'h0008);
      wr(8'h00, 16'h001B);
      rdc(8'h00, 16'h0010, 16'hFFFF);
      idle;
      rdc(8'h04, 16'h0010, 16'h003F);
      chk({8'h00, slv.seen[0]}, 16'h00A0 | k[15:0]);
      chk(irqs, 16'h0001);
      wr(8'h04, 16'h0737);
    end
    for (k = 1; k < 5; k = k + 1) begin
      lfsr = lfsr_n(lfsr);
      wd = lfsr[15:0];
      wr(8'h10, 16'h003C);
      wr(8'h0C, wd);
      wr(8'h08, 16'h00A0);
      go(k[2:0]);
      idle;
      rdc(8'h04, 16'h0010, 16'h003F);
      if (k == 1) chk({8'h00, slv.seen[1]}, {8'h00, wd[7:0]});
      else if (k == 4) rdc(8'h0C, 16'hFFFF, 16'hFFFF);
      else chk({slv.seen[1], slv.seen[2]}, {8'h3C, wd[7:0]});
      if (k == 3) chk({8'h00, slv.seen[3]}, {8'h00, wd[15:8]});
      wr(8'h04, 16'h0737);
    end
    nack_en <= 1'b1;
    go(3'h0);
    idle;
    rdc(8'h04, 16'h0004, 16'h001C);
    nack_en <= 1'b0;
    wr(8'h04, 16'h0737);
    go(3'h3);
    repeat (800) @(posedge hclk);
    for (k = 0; k < 400 && smb_clk_oe_n !== 1'b1; k = k + 1) @(posedge hclk);
    for (k = 0; k < 400 && smb_clk_oe_n !== 1'b0; k = k + 1) @(posedge hclk);
    chk({15'h0, smb_clk_oe_n}, 16'h0000);
    wr(8'h00, 16'h0030);
    idle;
    rdc(8'h04, 16'h0001, 16'h0019);
    close_out;
  end
endmodule // tb_top
